// file: design/emcf_defs.vh
// emcf_defs.vh: register map, field positions, reset values and timing for the mac framing block.
// assumes: included by emcf_mac; byte addresses on a 32-bit ahb-lite bus.
`ifndef EMCF_DEFS_VH
`define EMCF_DEFS_VH

// ================================================================
// register byte offsets
`define EMCF_OFS_MAC_CONTROL_1     6'h00
`define EMCF_OFS_MAC_CONTROL_3     6'h04
`define EMCF_OFS_MAC_CONTROL_4     6'h08
`define EMCF_OFS_MAX_FRAME_LENGTH  6'h0c
`define EMCF_OFS_BACK_TO_BACK_GAP  6'h10
`define EMCF_OFS_GAP_LOW_BYTE      6'h14
`define EMCF_OFS_GAP_HIGH_BYTE     6'h18
`define EMCF_OFS_MODULE_CONTROL_1  6'h1c
`define EMCF_OFS_MODULE_STATUS     6'h20
`define EMCF_OFS_RX_STATUS         6'h24
`define EMCF_OFS_STATION_ADDR_LO   6'h28
`define EMCF_OFS_STATION_ADDR_HI   6'h2c
`define EMCF_OFS_RX_CHECK_CONTROL  6'h30
`define EMCF_OFS_PHY_CONTROL_1     6'h34
`define EMCF_OFS_PHY_CONTROL_2     6'h38

// ================================================================
// field positions
`define EMCF_BIT_MAC_RX_ENABLE     0
`define EMCF_BIT_RX_PAUSE_ENABLE   2
`define EMCF_BIT_TX_PAUSE_ENABLE   3
`define EMCF_BIT_MAC_FULL_DUPLEX   0
`define EMCF_BIT_FRAME_LEN_CHECK   1
`define EMCF_BIT_HUGE_FRAME        2
`define EMCF_BIT_TX_CRC_ENABLE     4
`define EMCF_PAD_CONFIG_HI         7
`define EMCF_PAD_CONFIG_LO         5
`define EMCF_BIT_DEFER             6
`define EMCF_BIT_RECEIVE_ENABLE    2
`define EMCF_BIT_TRANSMIT_REQUEST  3
`define EMCF_BIT_MODULE_ENABLE     5
`define EMCF_BIT_PHY_READY         0
`define EMCF_BIT_RECEIVE_BUSY      2
`define EMCF_BIT_PHY_DUPLEX        8
`define EMCF_BIT_LOOPBACK_DISABLE  8
`define EMCF_BIT_AUX_RX_DISABLE    4

// ================================================================
// reset values and frame constants
`define EMCF_RST_MAX_FRAME_LENGTH  16'h05ee
`define EMCF_RST_ZERO8             8'h00
`define EMCF_MIN_PADDED_BYTES      16'h003c
`define EMCF_MIN_RX_BYTES          16'h0012
`define EMCF_MAX_LENGTH_FIELD      16'h05dc
`define EMCF_PREAMBLE_BYTES        3'h7
`define EMCF_PREAMBLE_BYTE         8'h55
`define EMCF_SFD_BYTE              8'hd5
`define EMCF_FD_GAP_ADJUST         8'h03
`define EMCF_HD_GAP_ADJUST         8'h06
`define EMCF_CRC_POLY              32'hedb88320
`define EMCF_CRC_RESIDUE           32'hdebb20e3

// ================================================================
// timing
`define EMCF_CLK_NS                10
`define EMCF_NIBBLE_NS             400
`define EMCF_PHY_START_US          1000
`define EMCF_PAUSE_QUANTUM_NS      51200

`endif

// file: design/emcf_mac.v
// emcf_mac: 10 mbit/s mac configuration, transmit framing and receive framing with an ahb-lite register slave.
// assumes: one clock hclk; the line side is a byte stream already in the hclk domain.
// Summary of operation
// - frames are accepted only while the mac receive enable bit is set.
// - full duplex with both pause enables honours received pause frames.
// - nonzero pad config zero-pads transmitted frames to at least 60 bytes.
// - without padding, undersized frames are sent exactly as the application gives them.
// - pad config or crc enable makes the transmitter append a valid crc.
// - the fcs is a 4-byte standard crc-32 over address through padding.
// - every received crc is checked; bad ones dropped only when check enabled.
// - frame length check enables reporting length field against actual data length.
// - frames longer than the programmed maximum length are cut off.
// - huge frame enable lifts the maximum length limit both ways.
// - full duplex gap equals the gap field plus 3 nibble times.
// - half duplex gap equals the gap field plus 6 nibble times.
// - station address is only stored and read back; it feeds neither receive filtering nor the transmitted source.
// - clearing module enable stops the module, hides phy registers, clears phy ready.
// - received frames shorter than 18 bytes are rejected.
// - preamble and sfd generated on transmit, stripped on receive; pad and crc kept.
`include "emcf_defs.vh"

module emcf_mac #(
	parameter PHY_START_CYCLES     = 100000,
	parameter PAUSE_QUANTUM_CYCLES = 5120
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire [7:0]  tx_data,
	input  wire        tx_valid,
	input  wire        tx_last,
	output wire        tx_ready,
	output reg  [7:0]  line_tx_data,
	output reg         line_tx_en,
	input  wire        line_carrier,
	input  wire [7:0]  line_rx_data,
	input  wire        line_rx_valid,
	input  wire        line_rx_dv,
	output reg  [7:0]  rx_data,
	output reg         rx_valid,
	output reg         rx_end,
	output reg         rx_drop,
	output reg         tx_done
);
	localparam NIBBLE_CYCLES = `EMCF_NIBBLE_NS / `EMCF_CLK_NS;
	localparam [1:0] T_IDLE = 2'h0, T_PRE = 2'h1, T_DATA = 2'h2, T_GAP = 2'h3;
	localparam [2:0] B_FRAME = 3'h0, B_PAD = 3'h1, B_FCS = 3'h2;
	localparam [1:0] R_IDLE = 2'h0, R_PRE = 2'h1, R_DATA = 2'h2;

	function [31:0] crc_byte;
		input [31:0] c;
		input [7:0]  d;
		integer      i;
		reg   [31:0] x;
		begin
			x = c ^ {24'h000000, d};
			for (i = 0; i < 8; i = i + 1)
				x = x[0] ? ((x >> 1) ^ `EMCF_CRC_POLY) : (x >> 1);
			crc_byte = x;
		end
	endfunction

	// expected pause frame header byte by index, bit 8 clear marks a byte that is not compared
	function [8:0] pause_hdr;
		input [15:0] idx;
		begin
			case (idx)
				16'h0000: pause_hdr = {1'b1, 8'h01};
				16'h0001: pause_hdr = {1'b1, 8'h80};
				16'h0002: pause_hdr = {1'b1, 8'hc2};
				16'h0003: pause_hdr = {1'b1, 8'h00};
				16'h0004: pause_hdr = {1'b1, 8'h00};
				16'h0005: pause_hdr = {1'b1, 8'h01};
				16'h000c: pause_hdr = {1'b1, 8'h88};
				16'h000d: pause_hdr = {1'b1, 8'h08};
				16'h000e: pause_hdr = {1'b1, 8'h00};
				16'h000f: pause_hdr = {1'b1, 8'h01};
				default:  pause_hdr = {1'b0, 8'h00};
			endcase
		end
	endfunction

	// ================================================================
	// registers
	reg        mac_rx_enable, rx_pause_enable, tx_pause_enable;
	reg [7:0]  mac_control_3;
	reg        defer_enable;
	reg [15:0] max_frame_length;
	reg [6:0]  back_to_back_gap_value;
	reg [7:0]  gap_low_byte, gap_high_byte;
	reg        receive_enable, transmit_request, module_enable;
	reg        phy_ready;
	reg [47:0] station_address;
	reg        rx_crc_check_enable;
	reg [15:0] phy_control_1, phy_control_2;
	reg [15:0] rx_last_count;
	reg [3:0]  rx_last_flags;
	reg        tx_aborted;

	wire       mac_full_duplex           = mac_control_3[`EMCF_BIT_MAC_FULL_DUPLEX];
	wire       frame_length_check_enable = mac_control_3[`EMCF_BIT_FRAME_LEN_CHECK];
	wire       huge_frame_enable         = mac_control_3[`EMCF_BIT_HUGE_FRAME];
	wire       tx_crc_enable             = mac_control_3[`EMCF_BIT_TX_CRC_ENABLE];
	wire [2:0] pad_config                = mac_control_3[`EMCF_PAD_CONFIG_HI:`EMCF_PAD_CONFIG_LO];

	// ================================================================
	// ahb-lite slave: writes finish with no wait, reads add one wait to register hrdata
	reg        dp_act, dp_write, rd_wait;
	reg [5:0]  dp_addr;
	wire       ap_take = hsel & htrans[1] & hready;
	wire       wr_go   = dp_act & dp_write;
	assign hreadyout = ~rd_wait;
	assign hresp     = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_act   <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 6'h00;
			rd_wait  <= 1'b0;
		end else begin
			if (hready) begin
				dp_act   <= ap_take;
				dp_write <= hwrite;
				dp_addr  <= {haddr[5:2], 2'b00};
			end
			rd_wait <= ap_take & ~hwrite;
		end
	end

	// tx/rx engines and events used by the register file
	reg  [1:0]  tx_state;
	reg  [2:0]  tx_body;
	reg  [15:0] pause_left;
	wire        rx_busy;
	reg         rx_good_end, rx_pause_hit;
	reg  [15:0] rx_quanta;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_wait) begin
			case (dp_addr)
				`EMCF_OFS_MAC_CONTROL_1:    hrdata <= {28'h0000000, tx_pause_enable, rx_pause_enable, 1'b0,
				                                       mac_rx_enable};
				`EMCF_OFS_MAC_CONTROL_3:    hrdata <= {24'h000000, mac_control_3};
				`EMCF_OFS_MAC_CONTROL_4:    hrdata <= {25'h0000000, defer_enable, 6'h00};
				`EMCF_OFS_MAX_FRAME_LENGTH: hrdata <= {16'h0000, max_frame_length};
				`EMCF_OFS_BACK_TO_BACK_GAP: hrdata <= {25'h0000000, back_to_back_gap_value};
				`EMCF_OFS_GAP_LOW_BYTE:     hrdata <= {24'h000000, gap_low_byte};
				`EMCF_OFS_GAP_HIGH_BYTE:    hrdata <= {24'h000000, gap_high_byte};
				`EMCF_OFS_MODULE_CONTROL_1: hrdata <= {26'h0000000, module_enable, 1'b0, transmit_request,
				                                       receive_enable, 2'b00};
				`EMCF_OFS_MODULE_STATUS:    hrdata <= {16'h0000, pause_left[15:1] != 15'h0000 || pause_left[0],
				                                       tx_aborted, 11'h000, rx_busy, 1'b0, phy_ready};
				`EMCF_OFS_RX_STATUS:        hrdata <= {12'h000, rx_last_flags, rx_last_count};
				`EMCF_OFS_STATION_ADDR_LO:  hrdata <= station_address[31:0];
				`EMCF_OFS_STATION_ADDR_HI:  hrdata <= {16'h0000, station_address[47:32]};
				`EMCF_OFS_RX_CHECK_CONTROL: hrdata <= {31'h00000000, rx_crc_check_enable};
				`EMCF_OFS_PHY_CONTROL_1:    hrdata <= module_enable ? {16'h0000, phy_control_1} : 32'h00000000;
				`EMCF_OFS_PHY_CONTROL_2:    hrdata <= module_enable ? {16'h0000, phy_control_2} : 32'h00000000;
				default:                    hrdata <= 32'h00000000;
			endcase
		end
	end

	// ================================================================
	// register writes
	reg [16:0] phy_timer;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mac_rx_enable          <= 1'b0;
			rx_pause_enable        <= 1'b0;
			tx_pause_enable        <= 1'b0;
			mac_control_3          <= `EMCF_RST_ZERO8;
			defer_enable           <= 1'b0;
			max_frame_length       <= `EMCF_RST_MAX_FRAME_LENGTH;
			back_to_back_gap_value <= 7'h00;
			gap_low_byte           <= `EMCF_RST_ZERO8;
			gap_high_byte          <= `EMCF_RST_ZERO8;
			receive_enable         <= 1'b0;
			transmit_request       <= 1'b0;
			module_enable          <= 1'b0;
			station_address        <= 48'h000000000000;
			rx_crc_check_enable    <= 1'b0;
			phy_control_1          <= 16'h0000;
			phy_control_2          <= 16'h0000;
			phy_ready              <= 1'b0;
			phy_timer              <= 17'h00000;
		end else begin
			// hardware clears first so a software set in the same cycle wins
			if (tx_done)
				transmit_request <= 1'b0;
			if (wr_go) begin
				case (dp_addr)
					`EMCF_OFS_MAC_CONTROL_1: begin
						mac_rx_enable   <= hwdata[`EMCF_BIT_MAC_RX_ENABLE];
						rx_pause_enable <= hwdata[`EMCF_BIT_RX_PAUSE_ENABLE];
						tx_pause_enable <= hwdata[`EMCF_BIT_TX_PAUSE_ENABLE];
					end
					`EMCF_OFS_MAC_CONTROL_3:    mac_control_3 <= hwdata[7:0];
					`EMCF_OFS_MAC_CONTROL_4:    defer_enable <= hwdata[`EMCF_BIT_DEFER];
					`EMCF_OFS_MAX_FRAME_LENGTH: max_frame_length <= hwdata[15:0];
					// bit 7 of the gap register is not stored and reads zero
					`EMCF_OFS_BACK_TO_BACK_GAP: back_to_back_gap_value <= hwdata[6:0];
					`EMCF_OFS_GAP_LOW_BYTE:     gap_low_byte <= hwdata[7:0];
					`EMCF_OFS_GAP_HIGH_BYTE:    gap_high_byte <= hwdata[7:0];
					`EMCF_OFS_MODULE_CONTROL_1: begin
						receive_enable   <= hwdata[`EMCF_BIT_RECEIVE_ENABLE];
						transmit_request <= hwdata[`EMCF_BIT_TRANSMIT_REQUEST] & hwdata[`EMCF_BIT_MODULE_ENABLE];
						module_enable    <= hwdata[`EMCF_BIT_MODULE_ENABLE];
					end
					`EMCF_OFS_STATION_ADDR_LO:  station_address[31:0] <= hwdata;
					`EMCF_OFS_STATION_ADDR_HI:  station_address[47:32] <= hwdata[15:0];
					`EMCF_OFS_RX_CHECK_CONTROL: rx_crc_check_enable <= hwdata[0];
					`EMCF_OFS_PHY_CONTROL_1:    if (module_enable) phy_control_1 <= hwdata[15:0];
					`EMCF_OFS_PHY_CONTROL_2:    if (module_enable) phy_control_2 <= hwdata[15:0];
					default: ;
				endcase
			end
			if (!module_enable) begin
				phy_ready <= 1'b0;
				phy_timer <= 17'h00000;
			end else if (phy_timer == PHY_START_CYCLES[16:0] - 17'h00001) begin
				phy_ready <= 1'b1;
			end else begin
				phy_timer <= phy_timer + 17'h00001;
			end
		end
	end

	// ================================================================
	// nibble-time enable; a byte takes two nibbles
	reg [5:0] nib_div;
	reg       nib_phase;
	wire      nib_tick  = (nib_div == NIBBLE_CYCLES[5:0] - 6'h01);
	wire      byte_tick = nib_tick & nib_phase;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nib_div   <= 6'h00;
			nib_phase <= 1'b0;
		end else if (nib_tick) begin
			nib_div   <= 6'h00;
			nib_phase <= ~nib_phase;
		end else begin
			nib_div <= nib_div + 6'h01;
		end
	end

	// ================================================================
	// transmitter
	reg [15:0] tx_count;
	reg [31:0] tx_crc;
	reg [2:0]  pre_cnt;
	reg [7:0]  gap_left;
	reg [1:0]  fcs_idx;
	wire       pad_on    = pad_config != 3'h0;
	wire       crc_on    = pad_on | tx_crc_enable;
	wire       tx_paused = pause_left != 16'h0000;
	assign tx_ready = (tx_state == T_DATA) && (tx_body == B_FRAME) && byte_tick && transmit_request;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state     <= T_IDLE;
			tx_body      <= B_FRAME;
			tx_count     <= 16'h0000;
			tx_crc       <= 32'hffffffff;
			pre_cnt      <= 3'h0;
			gap_left     <= 8'h00;
			fcs_idx      <= 2'h0;
			line_tx_data <= 8'h00;
			line_tx_en   <= 1'b0;
			tx_done      <= 1'b0;
			tx_aborted   <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (!module_enable) begin
				tx_state   <= T_IDLE;
				line_tx_en <= 1'b0;
			end else begin
				case (tx_state)
					T_IDLE: begin
						if (transmit_request && !tx_done && !tx_paused && byte_tick) begin
							if (!mac_full_duplex && line_carrier) begin
								if (!defer_enable) begin
									tx_aborted <= 1'b1;
									tx_done    <= 1'b1;
								end
							end else begin
								tx_state     <= T_PRE;
								tx_aborted   <= 1'b0;
								pre_cnt      <= 3'h0;
								line_tx_en   <= 1'b1;
								line_tx_data <= `EMCF_PREAMBLE_BYTE;
							end
						end
					end
					T_PRE: if (byte_tick) begin
						pre_cnt <= pre_cnt + 3'h1;
						// sfd leads straight into the first data byte so the line enable stays high
						if (pre_cnt == `EMCF_PREAMBLE_BYTES - 3'h1) begin
							line_tx_data <= `EMCF_SFD_BYTE;
							tx_state     <= T_DATA;
							tx_body      <= B_FRAME;
							tx_count     <= 16'h0000;
							tx_crc       <= 32'hffffffff;
						end
					end
					T_DATA: if (byte_tick) begin
						line_tx_en <= 1'b1;
						if (!transmit_request || (!huge_frame_enable && tx_count >= max_frame_length) ||
						    (tx_body == B_FRAME && !tx_valid)) begin
							tx_aborted <= 1'b1;
							line_tx_en <= 1'b0;
							tx_state   <= T_GAP;
						end else begin
							case (tx_body)
								B_FRAME: begin
									line_tx_data <= tx_data;
									tx_crc       <= crc_byte(tx_crc, tx_data);
									tx_count     <= tx_count + 16'h0001;
									if (tx_last)
										tx_body <= (pad_on && tx_count + 16'h0001 < `EMCF_MIN_PADDED_BYTES) ? B_PAD :
										           crc_on ? B_FCS : 3'h3;
								end
								B_PAD: begin
									line_tx_data <= 8'h00;
									tx_crc       <= crc_byte(tx_crc, 8'h00);
									tx_count     <= tx_count + 16'h0001;
									if (tx_count + 16'h0001 >= `EMCF_MIN_PADDED_BYTES)
										tx_body <= B_FCS;
								end
								B_FCS: begin
									line_tx_data <= ~tx_crc[8*fcs_idx +: 8];
									tx_count     <= tx_count + 16'h0001;
									fcs_idx      <= fcs_idx + 2'h1;
									if (fcs_idx == 2'h3)
										tx_body <= 3'h3;
								end
								default: begin
									line_tx_en <= 1'b0;
									tx_state   <= T_GAP;
								end
							endcase
						end
						gap_left <= {1'b0, back_to_back_gap_value} +
						            (mac_full_duplex ? `EMCF_FD_GAP_ADJUST : `EMCF_HD_GAP_ADJUST);
					end
					T_GAP: if (nib_tick) begin
						line_tx_en <= 1'b0;
						fcs_idx    <= 2'h0;
						if (gap_left <= 8'h01) begin
							tx_state <= T_IDLE;
							tx_done  <= 1'b1;
						end else begin
							gap_left <= gap_left - 8'h01;
						end
					end
					default: tx_state <= T_IDLE;
				endcase
			end
		end
	end

	// ================================================================
	// receiver
	reg [1:0]  rx_state;
	reg [15:0] rx_count, len_field;
	reg [31:0] rx_crc;
	reg        rx_long, hdr_match;
	assign rx_busy = rx_state != R_IDLE;
	wire [8:0]  exp_hdr  = pause_hdr(rx_count);
	wire [15:0] data_len = rx_count - 16'h0012;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state      <= R_IDLE;
			rx_count      <= 16'h0000;
			rx_crc        <= 32'hffffffff;
			rx_long       <= 1'b0;
			hdr_match     <= 1'b0;
			len_field     <= 16'h0000;
			rx_quanta     <= 16'h0000;
			rx_data       <= 8'h00;
			rx_valid      <= 1'b0;
			rx_end        <= 1'b0;
			rx_drop       <= 1'b0;
			rx_last_count <= 16'h0000;
			rx_last_flags <= 4'h0;
			rx_good_end   <= 1'b0;
			rx_pause_hit  <= 1'b0;
		end else begin
			rx_valid     <= 1'b0;
			rx_end       <= 1'b0;
			rx_drop      <= 1'b0;
			rx_good_end  <= 1'b0;
			rx_pause_hit <= 1'b0;
			if (!module_enable) begin
				rx_state <= R_IDLE;
			end else begin
				case (rx_state)
					R_IDLE: if (line_rx_dv && mac_rx_enable && receive_enable && phy_ready) begin
						rx_state  <= R_PRE;
						rx_count  <= 16'h0000;
						rx_crc    <= 32'hffffffff;
						rx_long   <= 1'b0;
						hdr_match <= 1'b1;
					end
					R_PRE: if (!line_rx_dv)
						rx_state <= R_IDLE;
					else if (line_rx_valid && line_rx_data == `EMCF_SFD_BYTE)
						rx_state <= R_DATA;
					R_DATA: if (!line_rx_dv) begin
						rx_state <= R_IDLE;
						rx_end   <= 1'b1;
						rx_drop  <= rx_count < `EMCF_MIN_RX_BYTES || rx_long ||
						            (rx_crc_check_enable && rx_crc != `EMCF_CRC_RESIDUE);
						rx_good_end   <= !(rx_count < `EMCF_MIN_RX_BYTES || rx_long ||
						                  (rx_crc_check_enable && rx_crc != `EMCF_CRC_RESIDUE));
						rx_pause_hit  <= hdr_match && rx_count >= `EMCF_MIN_RX_BYTES;
						rx_last_count <= rx_count;
						rx_last_flags <= {rx_long, rx_count < `EMCF_MIN_RX_BYTES,
						                  frame_length_check_enable && len_field <= `EMCF_MAX_LENGTH_FIELD &&
						                  len_field != data_len &&
						                  !(len_field < 16'h002e && data_len == 16'h002e),
						                  rx_crc != `EMCF_CRC_RESIDUE};
					end else if (line_rx_valid) begin
						rx_count <= rx_count + 16'h0001;
						rx_crc   <= crc_byte(rx_crc, line_rx_data);
						if (exp_hdr[8] && exp_hdr[7:0] != line_rx_data)
							hdr_match <= 1'b0;
						if (rx_count == 16'h000c)
							len_field[15:8] <= line_rx_data;
						if (rx_count == 16'h000d)
							len_field[7:0] <= line_rx_data;
						if (rx_count == 16'h0010)
							rx_quanta[15:8] <= line_rx_data;
						if (rx_count == 16'h0011)
							rx_quanta[7:0] <= line_rx_data;
						if (!huge_frame_enable && rx_count >= max_frame_length) begin
							rx_long <= 1'b1;
						end else begin
							rx_data  <= line_rx_data;
							rx_valid <= 1'b1;
						end
					end
					default: rx_state <= R_IDLE;
				endcase
			end
		end
	end

	// ================================================================
	// pause flow control: quanta counted in 512-bit-time units
	reg [12:0] quantum_cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_left  <= 16'h0000;
			quantum_cnt <= 13'h0000;
		end else if (!module_enable) begin
			pause_left <= 16'h0000;
		end else if (rx_good_end && rx_pause_hit && mac_full_duplex && rx_pause_enable && tx_pause_enable) begin
			pause_left  <= rx_quanta;
			quantum_cnt <= 13'h0000;
		end else if (pause_left != 16'h0000) begin
			if (quantum_cnt == PAUSE_QUANTUM_CYCLES[12:0] - 13'h0001) begin
				quantum_cnt <= 13'h0000;
				pause_left  <= pause_left - 16'h0001;
			end else begin
				quantum_cnt <= quantum_cnt + 13'h0001;
			end
		end
	end
endmodule

// file: verification/emcf_chk.sv
// emcf_chk: port checks of the mac framing block
// assumes: bound to emcf_mac, hready fed from hreadyout
module emcf_chk (
	input logic       hclk,
	input logic       hresetn,
	input logic       hsel,
	input logic [1:0] htrans,
	input logic       hwrite,
	input logic       hready,
	input logic       hreadyout,
	input logic [7:0] line_tx_data,
	input logic       line_tx_en,
	input logic       tx_done,
	input logic       line_rx_valid,
	input logic       line_rx_dv,
	input logic       rx_valid,
	input logic       rx_end,
	input logic       rx_drop
);
	timeunit 1ns;
	timeprecision 1ns;
	// ================================
	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_req; hsel && htrans[1] && hready && !hwrite; endsequence
	sequence rd_wait; !hreadyout ##1 hreadyout; endsequence
	chk_read_wait: assert property (rd_req |=> rd_wait) else $error("read wait wrong");
	chk_write_fast: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout) else $error("write stall");
	chk_tx_preamble: assert property ($rose(line_tx_en) |-> (line_tx_data == 8'h55) [*8])
		else $error("preamble wrong");
	chk_byte_hold: assert property (line_tx_en && $past(line_tx_en) && $changed(line_tx_data) |=>
		$stable(line_tx_data) [*8]) else $error("line byte not held");
	chk_done_idle: assert property (tx_done |-> !line_tx_en) else $error("done in frame");
	chk_rx_byte: assert property (rx_valid |-> $past(line_rx_valid)) else $error("stray byte");
	chk_rx_close: assert property (rx_end |-> !line_rx_dv && ($past(line_rx_dv) || $past(line_rx_dv, 2)))
		else $error("end not after frame");
	chk_drop_end: assert property (rx_drop |-> rx_end) else $error("drop without end");
endmodule
bind emcf_mac emcf_chk u_chk (.*);

// file: verification/emcf_node.sv
// emcf_node: remote station feeding frames to the receive side
// assumes: line bytes in the hclk domain, one strobe per four cycles
module emcf_node (
	input  logic       hclk,
	output logic [7:0] line_rx_data  = 8'h00,
	output logic       line_rx_valid = 1'b0,
	output logic       line_rx_dv    = 1'b0,
	output logic       line_carrier  = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;
	// ================================
	// frame source
	task automatic put(input logic [7:0] b);
		line_rx_data <= b;
		line_rx_valid <= 1'h1;
		@(posedge hclk);
		line_rx_valid <= 1'h0;
		// between strobes show the inverse so no stale byte looks valid
		line_rx_data <= ~b;
		repeat (3) @(posedge hclk);
	endtask
	task automatic send(input int n, input logic bad);
		logic [31:0] crc;
		crc = 32'hffffffff;
		line_rx_dv <= 1'h1;
		line_carrier <= 1'h1;
		for (int k = 0; k < 8; k++)
			put(k < 7 ? 8'h55 : 8'hd5);
		for (int k = 0; k < n; k++) begin
			for (int j = 0; j < 8; j++)
				crc = (crc >> 1) ^ ((crc[0] ^ k[j]) ? 32'hedb88320 : 32'h0);
			put(k[7:0]);
		end
		crc = ~crc ^ {31'h0, bad};
		for (int k = 0; k < 4; k++)
			put(crc[8*k +: 8]);
		line_rx_dv <= 1'h0;
		line_carrier <= 1'h0;
	endtask
endmodule

// file: verification/test_ethernet_mac_config_framing.sv
// test_ethernet_mac_config_framing: register, receive and transmit tests
// assumes: emcf_node is the remote station
module test_ethernet_mac_config_framing;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_valid = 0, tx_last = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, r;
	logic [7:0] tx_data = 0, b5;
	int miscompares = 0, checks_done = 0, nrx, ntx, nend, ndrop, nfr, t0;
	wire hreadyout, hresp, tx_ready, line_tx_en, line_carrier, line_rx_valid, line_rx_dv;
	wire rx_valid, rx_end, rx_drop, tx_done;
	wire [31:0] hrdata;
	wire [7:0] line_tx_data, line_rx_data, rx_data;
	emcf_mac #(.PHY_START_CYCLES(20), .PAUSE_QUANTUM_CYCLES(8)) dut (.hready(hreadyout), .*);
	emcf_node node (.*);
	// ================================
	// drivers and compares
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		nrx <= nrx + rx_valid;
		ntx <= ntx + line_tx_en;
		nend <= nend + rx_end;
		ndrop <= ndrop + rx_drop;
		nfr <= rx_end ? 0 : nfr + rx_valid;
		if (rx_valid && nfr == 5)
			b5 <= rx_data;
	end
	task automatic chk(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1);
		r = hrdata;
	endtask
	task automatic rxf(input int n, input logic bad, input logic [31:0] cnt, input logic drop);
		int n0, e0, d0;
		n0 = nrx;
		e0 = nend;
		d0 = ndrop;
		node.send(n, bad);
		repeat (4) @(posedge hclk);
		chk(nrx - n0, cnt);
		chk(nend - e0, cnt != 0);
		chk(ndrop - d0, drop);
		if (cnt != 0)
			chk(b5, 8'h05);
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#400000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1;
		bus(0, 8'h0c, 0);
		chk(r, 32'h05ee);
		bus(1, 8'h10, 32'hff);
		bus(0, 8'h10, 0);
		chk(r, 32'h7f);
		bus(1, 8'h34, 32'h100);
		bus(0, 8'h34, 0);
		chk(r, 0);
		bus(0, 8'h3c, 0);
		chk(r, 0);
		bus(1, 8'h1c, 32'h24);
		repeat (25) @(posedge hclk);
		bus(0, 8'h20, 0);
		chk(r, 32'h1);
		bus(1, 8'h08, 32'h40);
		bus(1, 8'h14, 32'h12);
		bus(1, 8'h18, 32'h0c);
		bus(1, 8'h34, 0);
		bus(1, 8'h38, 32'h110);
		bus(0, 8'h38, 0);
		chk(r, 32'h110);
		rxf(20, 0, 0, 0);
		bus(1, 8'h00, 1);
		bus(1, 8'h30, 1);
		rxf(20, 0, 24, 0);
		rxf(13, 0, 17, 1);
		rxf(20, 1, 24, 1);
		bus(1, 8'h30, 0);
		rxf(20, 1, 24, 0);
		bus(0, 8'h24, 0);
		chk(r, 32'h00010018);
		bus(1, 8'h0c, 32'h14);
		rxf(20, 0, 20, 1);
		bus(1, 8'h04, 32'h04);
		rxf(20, 0, 24, 0);
		bus(1, 8'h0c, 32'h5ee);
		bus(1, 8'h04, 32'h20);
		tx_data <= 8'hab;
		tx_valid <= 1;
		tx_last <= 1;
		t0 = ntx;
		bus(1, 8'h1c, 32'h2c);
		do @(posedge hclk); while (tx_ready !== 1);
		tx_valid <= 0;
		do @(posedge hclk); while (tx_done !== 1);
		chk((ntx - t0 + 40) / 80, 72);
		bus(0, 8'h1c, 0);
		chk(r[3], 0);
		tally_and_finish;
	end
endmodule
